// >>> rtl/flash_cmd_pkg.sv
package flash_cmd_pkg;

   // ----------------------------------------
   // Clock
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;

   // ----------------------------------------
   // Instruction codes
   // ----------------------------------------
   localparam logic [7:0] OP_STATUS_READ   = 8'h05;
   localparam logic [7:0] OP_PROG_SUSPEND  = 8'h85;
   localparam logic [7:0] OP_PROG_RESUME   = 8'h8a;
   localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
   localparam logic [7:0] OP_ERASE_RESUME  = 8'h7a;
   localparam logic [7:0] OP_PD_ENTER      = 8'hb9;
   localparam logic [7:0] OP_PD_EXIT       = 8'hab;
   localparam logic [7:0] OP_PARAM_READ    = 8'h5a;

   // ----------------------------------------
   // Power-down dword fields (MSB to LSB)
   // ----------------------------------------
   localparam logic       PD_SUPPORTED_FLAG = 1'b0;
   localparam logic [1:0] EXIT_UNIT_CODE    = 2'b01;
   localparam logic [4:0] EXIT_COUNT_CODE   = 5'b11101;
   localparam logic [3:0] RESERVED_FIELD_HI = 4'hf;
   localparam logic [1:0] POLL_METHOD_CODE  = 2'b01;
   localparam logic [1:0] RESERVED_FIELD_LO = 2'b11;

   localparam int PD_SUPPORTED_BIT = 31;
   localparam int PD_ENTER_LSB     = 23;
   localparam int PD_EXIT_LSB      = 15;
   localparam int EXIT_UNIT_LSB    = 13;
   localparam int EXIT_COUNT_LSB   = 8;
   localparam int RESERVED_HI_LSB  = 4;
   localparam int POLL_METHOD_LSB  = 2;
   localparam int RESERVED_LO_LSB  = 0;

   localparam logic [31:0] PD_DWORD =
      (32'(PD_SUPPORTED_FLAG) << PD_SUPPORTED_BIT) |
      (32'(OP_PD_ENTER)       << PD_ENTER_LSB)     |
      (32'(OP_PD_EXIT)        << PD_EXIT_LSB)      |
      (32'(EXIT_UNIT_CODE)    << EXIT_UNIT_LSB)    |
      (32'(EXIT_COUNT_CODE)   << EXIT_COUNT_LSB)   |
      (32'(RESERVED_FIELD_HI) << RESERVED_HI_LSB)  |
      (32'(POLL_METHOD_CODE)  << POLL_METHOD_LSB)  |
      (32'(RESERVED_FIELD_LO) << RESERVED_LO_LSB);

   localparam logic [31:0] SUSPEND_DWORD =
      {OP_ERASE_SUSPEND, OP_ERASE_RESUME, OP_PROG_SUSPEND, OP_PROG_RESUME};

   // ----------------------------------------
   // Table layout
   // ----------------------------------------
   localparam logic [7:0] SUSPEND_DWORD_OFFSET = 8'h30;
   localparam logic [7:0] PD_DWORD_OFFSET      = 8'h34;
   localparam logic [7:0] TABLE_FILL           = 8'hff;

   // ----------------------------------------
   // Status byte and wake timing
   // ----------------------------------------
   localparam int         PENDING_BIT     = 0;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam int         EXIT_UNIT_NS    = 1000;
   localparam int         EXIT_DELAY_NS   = (int'(EXIT_COUNT_CODE) + 1) * EXIT_UNIT_NS;
   localparam int         WAKE_CYCLES     = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         ADDR_BITS       = 24;
   localparam int         DUMMY_BITS      = 8;

   typedef enum logic [4:0] {
      ST_CMD    = 5'h01,
      ST_ADDR   = 5'h02,
      ST_DUMMY  = 5'h04,
      ST_SEND   = 5'h08,
      ST_IGNORE = 5'h10
   } spi_state_t;

endpackage

// >>> rtl/param_rom.sv
`timescale 1ns/1ns
module param_rom (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] addr,
   output logic      [7:0] rd_data
);

   wire       hit_susp = (addr[7:2] == flash_cmd_pkg::SUSPEND_DWORD_OFFSET[7:2]);
   wire       hit_pd   = (addr[7:2] == flash_cmd_pkg::PD_DWORD_OFFSET[7:2]);
   wire [31:0] dword   = hit_susp ? flash_cmd_pkg::SUSPEND_DWORD : flash_cmd_pkg::PD_DWORD;
   // Low byte at the lowest offset
   wire [7:0] lane     = dword[{addr[1:0], 3'b000} +: 8];
   wire [7:0] rd_next  = (hit_susp || hit_pd) ? lane : flash_cmd_pkg::TABLE_FILL;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= flash_cmd_pkg::TABLE_FILL;
      end else begin
         rd_data <= rd_next;
      end
   end

endmodule

// >>> rtl/flash_cmd_core.sv
`timescale 1ns/1ns
module flash_cmd_core (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic mosi,
   input  wire logic prog_running,
   output logic      miso,
   output logic      miso_oe,
   output logic      suspend_pulse,
   output logic      resume_pulse,
   output logic      prog_suspended,
   output logic      deep_pd,
   output logic      op_pending
);

   // ----------------------------------------
   // Link edges
   // ----------------------------------------
   logic                     sck_prev_reg;
   logic                     cs_prev_reg;
   flash_cmd_pkg::spi_state_t state_reg;
   logic [4:0]               bit_cnt_reg;
   logic [7:0]               shift_reg;
   logic [7:0]               opcode_reg;
   logic                     op_ready_reg;
   logic [7:0]               addr_reg;
   logic                     from_rom_reg;
   logic [2:0]               tx_cnt_reg;
   logic [7:0]               tx_reg;
   logic [10:0]              wake_cnt_reg;
   logic [7:0]               rom_data;

   wire sck_rise  = sck & ~sck_prev_reg & ~cs_n;
   wire sck_fall  = ~sck & sck_prev_reg & ~cs_n;
   wire cs_end    = cs_n & ~cs_prev_reg;
   wire [7:0] rx_byte   = {shift_reg[6:0], mosi};
   wire       last_cmd  = (bit_cnt_reg == 5'd7);
   wire       last_addr = (bit_cnt_reg == 5'(flash_cmd_pkg::ADDR_BITS - 1));
   wire       last_dumy = (bit_cnt_reg == 5'(flash_cmd_pkg::DUMMY_BITS - 1));

   // ----------------------------------------
   // Opcode decode
   // ----------------------------------------
   // While powered down only the exit opcode is heard
   wire rx_allowed = ~deep_pd | (rx_byte == flash_cmd_pkg::OP_PD_EXIT);
   wire rx_status  = rx_allowed & (rx_byte == flash_cmd_pkg::OP_STATUS_READ);
   wire rx_param   = rx_allowed & (rx_byte == flash_cmd_pkg::OP_PARAM_READ);

   wire do_cmd     = cs_end & op_ready_reg;
   wire do_suspend = do_cmd & (opcode_reg == flash_cmd_pkg::OP_PROG_SUSPEND)
                     & prog_running & ~prog_suspended;
   wire do_resume  = do_cmd & (opcode_reg == flash_cmd_pkg::OP_PROG_RESUME)
                     & prog_suspended;
   wire do_enter   = do_cmd & (opcode_reg == flash_cmd_pkg::OP_PD_ENTER);
   wire do_exit    = do_cmd & (opcode_reg == flash_cmd_pkg::OP_PD_EXIT) & deep_pd;

   wire pending_next = (prog_running & ~prog_suspended & ~do_suspend) | do_resume
                       | (wake_cnt_reg != 11'd0) | do_exit;
   wire [7:0] status_byte = flash_cmd_pkg::STATUS_RESET
                            | (8'(op_pending) << flash_cmd_pkg::PENDING_BIT);
   wire [7:0] cur_byte = from_rom_reg ? rom_data : status_byte;

   // ----------------------------------------
   // Receive state machine
   // ----------------------------------------
   flash_cmd_pkg::spi_state_t state_next;
   logic [4:0]                bit_cnt_next;
   logic                      op_ready_next;
   logic                      from_rom_next;

   always_comb begin
      state_next    = state_reg;
      bit_cnt_next  = bit_cnt_reg;
      op_ready_next = op_ready_reg;
      from_rom_next = from_rom_reg;
      if (cs_n) begin
         state_next    = flash_cmd_pkg::ST_CMD;
         bit_cnt_next  = 5'd0;
         op_ready_next = 1'b0;
      end else if (sck_rise) begin
         bit_cnt_next = bit_cnt_reg + 5'd1;
         case (state_reg)
            flash_cmd_pkg::ST_CMD: begin
               if (last_cmd) begin
                  bit_cnt_next = 5'd0;
                  if (rx_status) begin
                     state_next    = flash_cmd_pkg::ST_SEND;
                     from_rom_next = 1'b0;
                  end else if (rx_param) begin
                     state_next = flash_cmd_pkg::ST_ADDR;
                  end else begin
                     // Single-byte opcodes wait for the frame to end
                     state_next    = flash_cmd_pkg::ST_IGNORE;
                     op_ready_next = rx_allowed;
                  end
               end
            end
            flash_cmd_pkg::ST_ADDR: begin
               if (last_addr) begin
                  state_next   = flash_cmd_pkg::ST_DUMMY;
                  bit_cnt_next = 5'd0;
               end
            end
            flash_cmd_pkg::ST_DUMMY: begin
               if (last_dumy) begin
                  state_next    = flash_cmd_pkg::ST_SEND;
                  from_rom_next = 1'b1;
                  bit_cnt_next  = 5'd0;
               end
            end
            flash_cmd_pkg::ST_IGNORE: begin
               // Extra clocks cancel a single-byte opcode
               op_ready_next = 1'b0;
               bit_cnt_next  = 5'd0;
            end
            flash_cmd_pkg::ST_SEND: begin
               bit_cnt_next = 5'd0;
            end
            default: begin
               state_next = flash_cmd_pkg::ST_IGNORE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Transmit path
   // ----------------------------------------
   wire       tx_load   = sck_fall & (state_reg == flash_cmd_pkg::ST_SEND) & (tx_cnt_reg == 3'd0);
   wire       tx_shift  = sck_fall & (state_reg == flash_cmd_pkg::ST_SEND);
   wire [7:0] tx_next   = tx_load ? {cur_byte[6:0], 1'b0} : {tx_reg[6:0], 1'b0};
   wire       miso_next = tx_load ? cur_byte[7] : tx_reg[7];
   wire       take_addr = sck_rise & (state_reg == flash_cmd_pkg::ST_ADDR) & last_addr;
   // Next table byte fetched as each byte is loaded to go out
   wire [7:0] addr_next = take_addr ? rx_byte
                        : (tx_load & from_rom_reg) ? addr_reg + 8'd1 : addr_reg;

   param_rom u_rom (
      .clk     (clk),
      .sys_rst (sys_rst),
      .addr    (addr_reg),
      .rd_data (rom_data)
   );

   // ----------------------------------------
   // Power and suspend state
   // ----------------------------------------
   wire [10:0] wake_next = do_exit ? 11'(flash_cmd_pkg::WAKE_CYCLES)
                         : (wake_cnt_reg != 11'd0) ? wake_cnt_reg - 11'd1 : 11'd0;
   wire        pd_next   = do_enter ? 1'b1 : do_exit ? 1'b0 : deep_pd;
   wire        susp_next = do_suspend ? 1'b1
                         : (do_resume | ~prog_running) ? 1'b0 : prog_suspended;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sck_prev_reg <= 1'b0;
         cs_prev_reg  <= 1'b1;
         state_reg    <= flash_cmd_pkg::ST_CMD;
         bit_cnt_reg  <= 5'd0;
         op_ready_reg <= 1'b0;
         from_rom_reg <= 1'b0;
         shift_reg    <= 8'h00;
         addr_reg     <= 8'h00;
      end else begin
         sck_prev_reg <= sck;
         cs_prev_reg  <= cs_n;
         state_reg    <= state_next;
         bit_cnt_reg  <= bit_cnt_next;
         op_ready_reg <= op_ready_next;
         from_rom_reg <= from_rom_next;
         shift_reg    <= sck_rise ? rx_byte : shift_reg;
         addr_reg     <= addr_next;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         opcode_reg <= 8'h00;
         tx_cnt_reg <= 3'd0;
         tx_reg     <= 8'h00;
         miso       <= 1'b0;
         miso_oe    <= 1'b0;
      end else begin
         opcode_reg <= (sck_rise & last_cmd & (state_reg == flash_cmd_pkg::ST_CMD)) ? rx_byte : opcode_reg;
         tx_cnt_reg <= cs_n ? 3'd0 : tx_shift ? tx_cnt_reg + 3'd1 : tx_cnt_reg;
         tx_reg     <= tx_shift ? tx_next : tx_reg;
         miso       <= tx_shift ? miso_next : miso;
         miso_oe    <= ~cs_n & (state_next == flash_cmd_pkg::ST_SEND);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         suspend_pulse  <= 1'b0;
         resume_pulse   <= 1'b0;
         prog_suspended <= 1'b0;
         deep_pd        <= 1'b0;
         wake_cnt_reg   <= 11'd0;
         op_pending     <= 1'b0;
      end else begin
         suspend_pulse  <= do_suspend;
         resume_pulse   <= do_resume;
         prog_suspended <= susp_next;
         deep_pd        <= pd_next;
         wake_cnt_reg   <= wake_next;
         op_pending     <= pending_next;
      end
   end

endmodule

// >>> dv/spi_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// SPI host, mode 0, half period 3 clk
// ----------------------------------------
module spi_host_model (
   input  wire logic clk,
   input  wire logic miso,
   output logic      sck,
   output logic      cs_n,
   output logic      mosi
);
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic frame_start();
      tick(2);
      cs_n = 1'b0;
   endtask
   // Released data line flips so a stale bit never looks valid
   task automatic frame_end();
      tick(3);
      cs_n = 1'b1;
      mosi = ~mosi;
      tick(3);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         tick(3);
         rx[i] = miso;
         sck = 1'b1;
         tick(3);
         sck = 1'b0;
      end
   endtask
endmodule

// >>> dv/flash_cmd_core_sva.sv
`timescale 1ns/1ns
module flash_cmd_core_sva (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cs_n,
   input wire logic prog_running,
   input wire logic miso_oe,
   input wire logic suspend_pulse,
   input wire logic resume_pulse,
   input wire logic prog_suspended,
   input wire logic deep_pd,
   input wire logic op_pending
);
   // Cycles since wake while still busy; too long for a delay range
   logic        pd_prev;
   logic [15:0] wake_age;
   wire  [15:0] wake_age_next = (pd_prev & ~deep_pd) ? 16'h0001
                              : (wake_age != 16'h0000 && op_pending && !prog_running) ? wake_age + 16'h0001
                              : 16'h0000;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pd_prev  <= 1'b0;
         wake_age <= 16'h0000;
      end else begin
         pd_prev  <= deep_pd;
         wake_age <= wake_age_next;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sus_single_a: assert property (suspend_pulse |=> !suspend_pulse)
      else $error("suspend pulse too long");
   sus_sets_a: assert property (suspend_pulse |-> prog_suspended && !$past(prog_suspended))
      else $error("suspend pulse without new suspend");
   res_clears_a: assert property (resume_pulse |-> !prog_suspended && $past(prog_suspended))
      else $error("resume pulse without suspend");
   sus_rise_a: assert property ($rose(prog_suspended) |-> suspend_pulse)
      else $error("suspended without pulse");
   idle_quiet_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3)
      |-> !suspend_pulse && !resume_pulse)
      else $error("pulse outside frame end");
   pd_silent_a: assert property (deep_pd && $past(deep_pd) |-> !miso_oe)
      else $error("data driven in power-down");
   wake_busy_a: assert property ($fell(deep_pd) |-> ##[0:1] op_pending [*8])
      else $error("no busy after wake");
   wake_end_a: assert property (wake_age <= 16'd1520)
      else $error("wake busy too long");
   busy_flag_a: assert property (prog_running && $past(prog_running) && !prog_suspended
      && !$past(prog_suspended) && !deep_pd && !$past(deep_pd) |-> op_pending)
      else $error("busy flag low while programming");
endmodule
bind flash_cmd_core flash_cmd_core_sva chk_u (
   .clk            (clk),
   .sys_rst        (sys_rst),
   .cs_n           (cs_n),
   .prog_running   (prog_running),
   .miso_oe        (miso_oe),
   .suspend_pulse  (suspend_pulse),
   .resume_pulse   (resume_pulse),
   .prog_suspended (prog_suspended),
   .deep_pd        (deep_pd),
   .op_pending     (op_pending)
);

// >>> dv/flash_cmd_core_tb.sv
`timescale 1ns/1ns
module flash_cmd_core_tb;
   logic       clk;
   logic       sys_rst;
   logic       prog_running;
   logic       sck;
   logic       cs_n;
   logic       mosi;
   logic       miso;
   logic       miso_pin;
   logic       miso_oe;
   logic       suspend_pulse;
   logic       resume_pulse;
   logic       prog_suspended;
   logic       deep_pd;
   logic       op_pending;
   logic [7:0] rx;
   int         bad_count;
   int         num_checks;
   int         sus_cnt;
   int         res_cnt;
   int         oe_cnt;
   // Expected power-down dword, built field by field
   localparam logic [31:0] PD_EXP = {1'b0, 8'hb9, 8'hab, 2'b01, 5'b11101, 4'hf, 2'b01, 2'b11};
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   flash_cmd_core dut_u (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
      .prog_running(prog_running), .miso(miso), .miso_oe(miso_oe), .suspend_pulse(suspend_pulse),
      .resume_pulse(resume_pulse), .prog_suspended(prog_suspended), .deep_pd(deep_pd), .op_pending(op_pending));
   // Pull-up on the data line while the device lets go of it
   assign miso_pin = miso_oe ? miso : 1'b1;
   spi_host_model host_u (.clk(clk), .miso(miso_pin), .sck(sck), .cs_n(cs_n), .mosi(mosi));
   always @(posedge clk) begin
      if (suspend_pulse === 1'b1) sus_cnt++;
      if (resume_pulse === 1'b1) res_cnt++;
      if (miso_oe === 1'b1) oe_cnt++;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op);
      host_u.frame_start();
      host_u.xfer(op, rx);
      host_u.frame_end();
   endtask
   task automatic status(output logic [7:0] st);
      host_u.frame_start();
      host_u.xfer(8'h05, st);
      host_u.xfer(8'h00, st);
      host_u.frame_end();
   endtask
   task automatic test_suspend();
      logic [7:0] st;
      prog_running = 1'b1;
      host_u.tick(4);
      status(st);
      check("status_busy", st, 16'h0001);
      cmd(8'h85);
      check("suspended", prog_suspended, 16'h0001);
      status(st);
      check("status_ready", st, 16'h0000);
      cmd(8'h8a);
      check("pulses", {8'(sus_cnt), 8'(res_cnt)}, 16'h0101);
      check("resumed", prog_suspended, 16'h0000);
      prog_running = 1'b0;
      cmd(8'h85);
      check("idle_suspend", {8'(sus_cnt), 7'h00, prog_suspended}, 16'h0100);
      cmd(8'h8a);
      check("idle_resume", 16'(res_cnt), 16'h0001);
      $display("test_suspend done");
   endtask
   task automatic test_table();
      logic [39:0] hdr;
      hdr = 40'h5a00003400;
      host_u.frame_start();
      for (int k = 4; k >= 0; k--) host_u.xfer(hdr[8*k +: 8], rx);
      for (int i = 0; i < 4; i++) begin
         host_u.xfer(8'h00, rx);
         check("pd_dword_byte", rx, 16'(PD_EXP[8*i +: 8]));
      end
      host_u.frame_end();
      $display("test_table done");
   endtask
   task automatic test_pd();
      logic [7:0] st;
      int         n;
      cmd(8'hb9);
      check("deep_pd", deep_pd, 16'h0001);
      oe_cnt = 0;
      status(st);
      check("pd_silent", 16'(oe_cnt), 16'h0000);
      check("pd_status", st, 16'h00ff);
      cmd(8'hab);
      check("woken", {deep_pd, op_pending}, 16'h0001);
      n = 0;
      // Host holds off until busy clears; bounded at 2000 clk
      while (op_pending === 1'b1 && n < 2000) begin
         host_u.tick(1);
         n++;
      end
      if (n >= 2000) begin
         bad_count++;
         end_of_test();
      end
      check("wake_length", 16'(n >= 1490 && n <= 1510), 16'h0001);
      status(st);
      check("status_after_wake", st, 16'h0000);
      $display("test_pd done");
   endtask
   initial begin
      sys_rst = 1'b1;
      prog_running = 1'b0;
      bad_count = 0;
      num_checks = 0;
      sus_cnt = 0;
      res_cnt = 0;
      oe_cnt = 0;
      repeat (8) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      host_u.tick(2);
      test_suspend();
      test_table();
      test_pd();
      end_of_test();
   end
endmodule
